// *** logic/por_device.sv ***
// processor-side reset response: bus release, cache clear, strap capture
// assumes sys_rst_l and straps are synchronous to sys_clk
module por_device #(
  parameter int unsigned LINES = por_pkg::CACHE_LINES,
  parameter int unsigned SELFTEST = por_pkg::SELFTEST_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic bus_req,
  input wire logic [por_pkg::BUS_W-1:0] bus_data,
  input wire logic [$clog2(LINES)-1:0] fill_line,
  input wire logic fill_en,
  output logic [por_pkg::CFG_W-1:0] config_straps,
  output logic selftest_busy,
  output logic outputs_floated,
  output logic running,
  output logic [LINES-1:0] line_valid,
  por_if.dev link
);
  typedef enum logic [1:0] {D_RESET = 2'b00, D_BIST = 2'b01, D_RUN = 2'b11, D_FLOAT = 2'b10} dev_e;
  dev_e state_q, state_d;
  logic rst_seen_q;
  logic [por_pkg::CFG_W-1:0] cfg_q;
  logic [LINES-1:0] valid_q;
  logic [15:0] bist_q;
  logic [por_pkg::BUS_W-1:0] out_q;
  logic oe_q;
  logic busy_q, float_q, run_q;
  wire in_reset = ~link.sys_rst_l;
  // release edge: reset seen last cycle, gone now
  wire release_edge = rst_seen_q & link.sys_rst_l;
  wire bist_done = bist_q >= 16'(SELFTEST - 1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      D_RESET: begin
        if (release_edge) begin
          if (!link.mgmt_irq_l) state_d = D_FLOAT;
          else if (!link.soft_init_l) state_d = D_BIST;
          else state_d = D_RUN;
        end
      end
      D_BIST: if (bist_done) state_d = D_RUN;
      D_RUN: state_d = D_RUN;
      D_FLOAT: state_d = D_FLOAT;
    endcase
    if (in_reset) state_d = D_RESET;
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= D_RESET;
      rst_seen_q <= 1'b1;
      cfg_q <= por_pkg::CFG_RESET;
      valid_q <= '0;
      bist_q <= 16'h0;
      out_q <= por_pkg::BUS_IDLE;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      float_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rst_seen_q <= in_reset;
      if (release_edge) cfg_q <= link.bus_in;
      bist_q <= (state_q == D_BIST) ? bist_q + 16'h1 : 16'h0;
      // lines dropped, never written back
      if (in_reset) valid_q <= '0;
      else if (fill_en && state_q == D_RUN) valid_q[fill_line] <= 1'b1;
      // one cycle from seeing reset, inside the two allowed
      oe_q <= (state_d == D_RUN) && bus_req;
      out_q <= ((state_d == D_RUN) && bus_req) ? bus_data : por_pkg::BUS_IDLE;
      busy_q <= state_d == D_BIST;
      float_q <= state_d == D_FLOAT;
      run_q <= state_d == D_RUN;
    end
  end

  // socket pin tied to ground permanently
  assign link.socket_present_l = 1'b0;
  assign link.bus_out = out_q;
  assign link.bus_oe = oe_q;
  assign config_straps = cfg_q;
  assign selftest_busy = busy_q;
  assign outputs_floated = float_q;
  assign running = run_q;
  assign line_valid = valid_q;
endmodule : por_device

// *** logic/por_pkg.sv ***
// constants shared by the power sequencer and the processor-side reset logic
// assumes a single 200 MHz system clock shared by both ends
package por_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned HOLD_MIN_US = 1000;
  localparam int unsigned HOLD_MAX_US = 10000;
  localparam int unsigned HOLD_MIN_CYC = HOLD_MIN_US * CLK_MHZ;
  localparam int unsigned HOLD_MAX_CYC = HOLD_MAX_US * CLK_MHZ;
  localparam int unsigned STABLE_FILTER_CYC = 16;
  localparam int unsigned RELEASE_CYC = 2;
  localparam int unsigned BUS_W = 8;
  localparam int unsigned CFG_W = 8;
  localparam int unsigned SELFTEST_CYC = 64;
  localparam int unsigned CACHE_LINES = 16;
  localparam logic [BUS_W-1:0] BUS_IDLE = 8'h00;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
endpackage : por_pkg

// *** logic/por_if.sv ***
// carrier joining the board power sequencer and the processor reset logic
interface por_if;
  logic supply_ok_in;
  logic sys_rst_l;
  logic soft_init_l;
  logic mgmt_irq_l;
  logic socket_present_l;
  logic [por_pkg::BUS_W-1:0] bus_in;
  logic [por_pkg::BUS_W-1:0] bus_out;
  logic bus_oe;
  modport seq (
    output supply_ok_in,
    output sys_rst_l,
    output soft_init_l,
    output mgmt_irq_l,
    input socket_present_l
  );
  modport dev (
    input supply_ok_in,
    input sys_rst_l,
    input soft_init_l,
    input mgmt_irq_l,
    input bus_in,
    output socket_present_l,
    output bus_out,
    output bus_oe
  );
endinterface : por_if

// *** logic/por_sequencer.sv ***
// board sequencer: power-good and system reset generation
// assumes supply and clock status arrive as synchronous levels
module por_sequencer #(
  parameter int unsigned HOLD_MIN = por_pkg::HOLD_MIN_CYC,
  parameter int unsigned HOLD_MAX = por_pkg::HOLD_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic core_supply_ok,
  input wire logic bus_ref_clock_ok,
  input wire logic init_req,
  input wire logic mgmt_req,
  output logic proc_present,
  output logic rst_active,
  por_if.seq link
);
  typedef enum logic [1:0] {S_OFF = 2'b00, S_FILT = 2'b01, S_HOLD = 2'b11, S_RUN = 2'b10} seq_e;
  seq_e state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic pg_q, rst_l_q, init_l_q, mgmt_l_q, pres_q, act_q;
  wire stable = core_supply_ok & bus_ref_clock_ok;
  wire filt_done = cnt_q >= por_pkg::STABLE_FILTER_CYC - 1;
  // release no earlier than min, never later than max
  wire hold_done = (cnt_q >= HOLD_MIN - 1) || (cnt_q >= HOLD_MAX - 1);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 32'h1;
    unique case (state_q)
      S_OFF: begin
        cnt_d = 32'h0;
        if (stable) state_d = S_FILT;
      end
      S_FILT: begin
        // re-stabilise before each new power-good rise
        if (!stable) begin
          state_d = S_OFF;
        end else if (filt_done) begin
          state_d = S_HOLD;
          cnt_d = 32'h0;
        end
      end
      S_HOLD: begin
        if (!stable) state_d = S_OFF;
        else if (hold_done) state_d = S_RUN;
      end
      S_RUN: begin
        cnt_d = 32'h0;
        if (!stable) state_d = S_OFF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= S_OFF;
      cnt_q <= 32'h0;
      pg_q <= 1'b0;
      rst_l_q <= 1'b0;
      init_l_q <= 1'b1;
      mgmt_l_q <= 1'b1;
      pres_q <= 1'b0;
      act_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      // power-good is a registered level, low until stable, no glitch
      // held high through run, so boundary scan sees it high
      pg_q <= (state_d == S_HOLD) || (state_d == S_RUN);
      // reset held whenever power-good low
      rst_l_q <= (state_d == S_RUN);
      act_q <= (state_d != S_RUN);
      init_l_q <= ~init_req;
      mgmt_l_q <= ~mgmt_req;
      pres_q <= ~link.socket_present_l;
    end
  end

  assign link.supply_ok_in = pg_q;
  assign link.sys_rst_l = rst_l_q;
  assign link.soft_init_l = init_l_q;
  assign link.mgmt_irq_l = mgmt_l_q;
  assign proc_present = pres_q;
  assign rst_active = act_q;
endmodule : por_sequencer

// *** tb/por_link_monitor.sv ***
// checker on the sequencer/device link signals
// assumes one sys_clk domain and a 20-cycle minimum hold in the bench
module por_link_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic supply_ok_in,
  input wire logic sys_rst_l,
  input wire logic mgmt_irq_l,
  input wire logic socket_present_l,
  input wire logic bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  a_socket_held_low: assert property (!socket_present_l)
    else $error("socket pin not low");
  a_bus_release_fast: assert property (!sys_rst_l |=> !bus_oe)
    else $error("bus driven in reset");
  a_reset_follows_pg: assert property (!supply_ok_in |=> !sys_rst_l)
    else $error("reset released without power good");
  a_hold_after_pg: assert property ($rose(sys_rst_l) |-> $past(supply_ok_in, 19))
    else $error("reset hold too short");
  a_hold_not_long: assert property ($rose(supply_ok_in) |-> ##[1:22] (sys_rst_l || !supply_ok_in))
    else $error("reset held too long");
  a_pg_refilter: assert property ($fell(supply_ok_in) |=> !supply_ok_in [*8])
    else $error("power good back too soon");
  a_pg_clean_rise: assert property ($rose(supply_ok_in) |-> !$past(supply_ok_in, 8))
    else $error("power good rose without low period");
  a_float_on_mgmt: assert property ($rose(sys_rst_l) && !mgmt_irq_l |=> !bus_oe [*8])
    else $error("bus driven after float release");
  c_release: cover property ($rose(sys_rst_l));
  c_float: cover property ($rose(sys_rst_l) && !mgmt_irq_l);
  c_drop: cover property ($fell(supply_ok_in));
endmodule : por_link_monitor

// *** tb/power_on_reset_sequencing_test.sv ***
// bench: sequencer and device joined by por_if
// assumes por_pkg, por_if and both design ends compiled first
module power_on_reset_sequencing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, stable, init_req, mgmt_req, bus_req, fill_en;
  logic proc_present, rst_active, selftest_busy, outputs_floated, running;
  logic [3:0] fill_line;
  logic [7:0] config_straps;
  logic [15:0] line_valid;
  int num_errors = 0, cmp_count = 0, cyc = 0, hold;
  por_if link ();
  // short holds keep the run small; expectations use 20
  por_sequencer #(.HOLD_MIN(20), .HOLD_MAX(200)) i_por_sequencer (.sys_clk(sys_clk),
    .reset_n(reset_n), .core_supply_ok(stable), .bus_ref_clock_ok(stable), .init_req(init_req),
    .mgmt_req(mgmt_req), .proc_present(proc_present), .rst_active(rst_active), .link(link.seq));
  por_device i_por_device (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
    .bus_data(8'hA5), .fill_line(fill_line), .fill_en(fill_en), .config_straps(config_straps),
    .selftest_busy(selftest_busy), .outputs_floated(outputs_floated), .running(running),
    .line_valid(line_valid), .link(link.dev));
  por_link_monitor i_por_link_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
    .supply_ok_in(link.supply_ok_in), .sys_rst_l(link.sys_rst_l), .mgmt_irq_l(link.mgmt_irq_l),
    .socket_present_l(link.socket_present_l), .bus_oe(link.bus_oe));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // power cycle; bus_req is left high from the second call on so a late bus release shows
  task automatic power_up(input logic ini, input logic mgm, input logic [7:0] straps);
    stable = 1'b0;
    init_req = ini;
    mgmt_req = mgm;
    link.bus_in = straps;
    repeat (4) @(negedge sys_clk);
    check({link.supply_ok_in, rst_active, link.bus_oe, line_valid}, 24'h020000);
    stable = 1'b1;
    hold = 0;
    while (rst_active !== 1'b0 && hold < 200) begin
      @(negedge sys_clk);
      hold++;
    end
    check(hold inside {[36:40]}, 24'h1);
    @(negedge sys_clk);
    check(config_straps, straps);
  endtask : power_up
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    reset_n = 1'b0;
    {stable, init_req, mgmt_req, bus_req, fill_en} = 5'h00;
    fill_line = 4'h3;
    link.bus_in = 8'h00;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    power_up(1'b0, 1'b0, 8'h3C);
    check({proc_present, running, selftest_busy, link.supply_ok_in}, 24'hD);
    fill_en = 1'b1;
    bus_req = 1'b1;
    @(negedge sys_clk);
    fill_en = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({link.bus_oe, line_valid}, 24'h010008);
    check(link.bus_out, 24'hA5);
    power_up(1'b1, 1'b0, 8'hC3);
    check(selftest_busy, 24'h1);
    // self-test stands for exactly its cycle count, then run
    repeat (por_pkg::SELFTEST_CYC - 1) @(negedge sys_clk);
    check({running, selftest_busy}, 24'h1);
    @(negedge sys_clk);
    check({running, selftest_busy}, 24'h2);
    power_up(1'b0, 1'b1, 8'h81);
    repeat (3) @(negedge sys_clk);
    check({outputs_floated, link.bus_oe}, 24'h2);
    complete_run();
  end
endmodule : power_on_reset_sequencing_test
